// ===== bur_pkg.sv
package bur_pkg;

   // ------------------------------------------------------------
   // register window: printed offsets are indices, byte addr = 4*idx
   // ------------------------------------------------------------
   localparam logic [2:0] OFF_DATA = 3'h0;     // data / divisor low / id
   localparam logic [2:0] OFF_ENAB = 3'h1;     // event enable / div high
   localparam logic [2:0] OFF_EVID = 3'h2;     // event id / fifo setup
   localparam logic [2:0] OFF_LFBS = 3'h3;     // line format / bank select
   localparam logic [2:0] OFF_MCTL = 3'h4;     // modem control / ext two
   localparam logic [2:0] OFF_LSTA = 3'h5;     // link status
   localparam logic [2:0] OFF_MSTA = 3'h6;     // modem status / tx level
   localparam logic [2:0] OFF_AUXS = 3'h7;     // scratch / aux / rx level
   localparam logic [3:0] IDX_IRQ_STAT = 4'h8; // sticky event status
   localparam logic [3:0] IDX_IRQ_MASK = 4'h9; // event mask
   localparam logic [3:0] IDX_LAST = 4'h9;     // highest mapped index

   // ------------------------------------------------------------
   // field positions, codes and reset values
   // ------------------------------------------------------------
   localparam int SEL_EN_BIT = 7;              // bank select enable
   localparam int EXT_MODE_BIT = 0;            // extended mode in ext one
   localparam logic [7:0] SEL_BANK2 = 8'hE0;   // bank 2 selector
   localparam logic [7:0] SEL_BANK3 = 8'hE4;   // bank 3 selector
   localparam logic [7:0] RST_BYTE = 8'h00;    // reset of every byte
   localparam logic [7:0] EN_STD_MASK = 8'h0F; // enables, basic mode
   localparam logic [7:0] EN_EXT_MASK = 8'h2F; // enables, extended mode
   localparam logic [7:0] EN_DMA_MASK = 8'h10; // dma enable, port two
   localparam logic [7:0] MC_STD_MASK = 8'h1F; // modem ctl, basic mode
   localparam logic [7:0] MC_EXT_MASK = 8'h0B; // deferral, rts, dtr
   localparam logic [7:0] FS_KEEP_MASK = 8'hF1; // fifo resets self-clear
   localparam logic [7:0] AUX_PORT2_MASK = 8'h74; // port-two aux flags
   localparam logic [1:0] PRI_LINE = 2'h3;     // line status pending
   localparam logic [1:0] PRI_RXDAT = 2'h2;    // rx data / timeout
   localparam logic [1:0] PRI_TXE = 2'h1;      // tx room
   localparam logic [1:0] PRI_MODEM = 2'h0;    // modem change
   localparam int EV_W = 7;                    // event source count
   localparam int EV_RXT = 6;                  // rx timeout event bit
   localparam logic [EV_W-1:0] EV_ZERO = 7'h00;

   typedef enum logic [2:0] {
      BUR_BANK0, BUR_BANK1, BUR_BANK2, BUR_BANK3, BUR_BANK_NONE
   } bur_bank_e;

   typedef enum logic {BUR_IDLE, BUR_ACCESS} bur_phase_e;

   // link-side inputs from the serial engine
   typedef struct packed {
      logic [7:0] rx_byte;      // head of receive fifo
      logic [7:0] link_status;  // line status byte
      logic [7:0] modem_status; // modem status byte
      logic [7:0] aux_flags;    // aux status flags
      logic [4:0] tx_level;     // tx fifo fill
      logic [4:0] rx_level;     // rx fifo fill
      logic [EV_W-1:0] events;  // live event levels
   } bur_link_in_s;

   // control outputs towards the serial engine
   typedef struct packed {
      logic [7:0] tx_byte;      // byte to send
      logic tx_load;            // one-cycle push of tx_byte
      logic rx_pop;             // one-cycle pop of rx_byte
      logic [15:0] divisor;     // baud divisor
      logic [15:0] legacy_div;  // legacy baud divisor
      logic [6:0] line_format;  // line format bits 6..0
      logic [7:0] fifo_setup;   // fifo setup incl. reset pulses
      logic [7:0] modem_ctl;    // modem/mode control
      logic [7:0] ext_one;      // extended control one
      logic [7:0] ext_two;      // extended control two
   } bur_ctrl_s;

   // the whole state of the block
   typedef struct packed {
      bur_phase_e phase;        // bus phase
      logic [3:0] idx;          // captured register index
      logic hit;                // captured address is mapped
      logic wr;                 // captured direction
      logic hready;             // hreadyout
      logic hresp;              // hresp
      logic [31:0] hrdata;      // read data
      logic [7:0] sel;          // last bank select byte
      logic [7:0] enables;      // event enable
      logic [7:0] scratch;      // scratch byte
      logic [EV_W-1:0] status;  // sticky events
      logic [EV_W-1:0] mask;    // event mask
      logic irq;                // interrupt
      bur_ctrl_s ctrl;          // outputs
   } bur_state_s;

   // decode the select byte into a bank
   function automatic bur_bank_e bur_bank(input logic [7:0] s);
      bur_bank_e b;
      b = BUR_BANK_NONE;
      if (!s[7]) begin
         b = BUR_BANK0;
      end else if (!s[6] || s[1] || s[0]) begin
         b = BUR_BANK1;
      end else if (s == SEL_BANK2) begin
         b = BUR_BANK2;
      end else if (s == SEL_BANK3) begin
         b = BUR_BANK3;
      end
      return b;
   endfunction : bur_bank

endpackage : bur_pkg

// ===== bur_regs.sv
`timescale 1ns/1ps

module bur_regs
   import bur_pkg::*;
#(
   parameter bit SECOND_PORT = 1'b1,        // port with dma events
   parameter logic [7:0] MODULE_REV = 8'h5A // arbitrary id value
) (
   input wire logic sys_clk,                // 40 MHz clock
   input wire logic reset,                  // sync, active high
   input wire logic clk_en,                 // freezes all when low
   input wire logic hsel,                   // ahb select
   input wire logic [31:0] haddr,           // ahb address
   input wire logic [1:0] htrans,           // ahb transfer type
   input wire logic hwrite,                 // ahb direction
   input wire logic [2:0] hsize,            // ahb size, word only
   input wire logic [31:0] hwdata,          // ahb write data
   input wire logic hready,                 // ahb bus ready
   output logic hreadyout,                  // ahb slave ready
   output logic hresp,                      // ahb response, okay
   output logic [31:0] hrdata,              // ahb read data
   input wire bur_link_in_s link_in,        // serial engine state
   output bur_ctrl_s ctrl,                  // serial engine control
   output logic irq                         // level interrupt
);

   // ------------------------------------------------------------
   // state and derived terms
   // ------------------------------------------------------------
   bur_state_s st_ff;                       // registered state
   bur_state_s nxt_st;                      // next state
   bur_bank_e bank;                         // active bank
   logic ext_mode;                          // extended mode on
   logic [7:0] rd_byte;                     // decoded read value
   logic [7:0] wbyte;                       // written byte
   logic [7:0] evid;                        // event id value
   logic [7:0] en_mask;                     // writable enable bits
   logic [EV_W-1:0] ev_en;                  // enables per source

   assign bank = bur_bank(st_ff.sel);
   assign ext_mode = st_ff.ctrl.ext_one[EXT_MODE_BIT];
   assign wbyte = hwdata[7:0];

   // ------------------------------------------------------------
   // event identification
   // ------------------------------------------------------------
   // extended enable bits
   always_comb begin
      en_mask = EN_STD_MASK;
      if (ext_mode) begin
         en_mask = SECOND_PORT ? (EN_EXT_MASK | EN_DMA_MASK) : EN_EXT_MASK;
      end
   end

   assign ev_en = {st_ff.enables[0], st_ff.enables[5:0]};

   // priority coded id in basic mode, flags in extended
   always_comb begin
      evid = RST_BYTE;
      if (ext_mode) begin
         evid[5:0] = link_in.events[5:0] & st_ff.enables[5:0];
      end else begin
         evid[7:6] = {2{st_ff.ctrl.fifo_setup[0]}};
         evid[0] = 1'b1;
         if (ev_en[2] && link_in.events[2]) begin
            evid[2:1] = PRI_LINE;
            evid[0] = 1'b0;
         end else if (ev_en[EV_RXT] && link_in.events[EV_RXT]) begin
            evid[3] = 1'b1;
            evid[2:1] = PRI_RXDAT;
            evid[0] = 1'b0;
         end else if (ev_en[0] && link_in.events[0]) begin
            evid[2:1] = PRI_RXDAT;
            evid[0] = 1'b0;
         end else if (ev_en[1] && link_in.events[1]) begin
            evid[2:1] = PRI_TXE;
            evid[0] = 1'b0;
         end else if (ev_en[3] && link_in.events[3]) begin
            evid[2:1] = PRI_MODEM;
            evid[0] = 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // read decode
   // ------------------------------------------------------------
   // every bank answers inside the same eight offsets
   always_comb begin
      rd_byte = RST_BYTE;
      if (st_ff.idx[2:0] == OFF_LFBS) begin
         rd_byte = st_ff.sel[SEL_EN_BIT] ? st_ff.sel
                   : {1'b0, st_ff.ctrl.line_format};
      end else begin
         case (bank)
            BUR_BANK0: begin
               case (st_ff.idx[2:0])
                  OFF_DATA: rd_byte = link_in.rx_byte;
                  OFF_ENAB: rd_byte = st_ff.enables;
                  OFF_EVID: rd_byte = evid;
                  OFF_MCTL: rd_byte = st_ff.ctrl.modem_ctl;
                  OFF_LSTA: rd_byte = link_in.link_status;
                  OFF_MSTA: rd_byte = link_in.modem_status;
                  // scratch or aux with timeout flag
                  OFF_AUXS: begin
                     if (ext_mode) begin
                        rd_byte = SECOND_PORT ?
                                  (link_in.aux_flags & AUX_PORT2_MASK)
                                  : RST_BYTE;
                        rd_byte[0] = link_in.events[EV_RXT];
                     end else begin
                        rd_byte = st_ff.scratch;
                     end
                  end
                  default: rd_byte = RST_BYTE;
               endcase
            end
            BUR_BANK1: begin
               case (st_ff.idx[2:0])
                  OFF_DATA: rd_byte = st_ff.ctrl.legacy_div[7:0];
                  OFF_ENAB: rd_byte = st_ff.ctrl.legacy_div[15:8];
                  default: rd_byte = RST_BYTE;
               endcase
            end
            BUR_BANK2: begin
               case (st_ff.idx[2:0])
                  OFF_DATA: rd_byte = st_ff.ctrl.divisor[7:0];
                  OFF_ENAB: rd_byte = st_ff.ctrl.divisor[15:8];
                  OFF_EVID: rd_byte = st_ff.ctrl.ext_one;
                  OFF_MCTL: rd_byte = st_ff.ctrl.ext_two;
                  OFF_MSTA: rd_byte = {3'h0, link_in.tx_level};
                  OFF_AUXS: rd_byte = {3'h0, link_in.rx_level};
                  default: rd_byte = RST_BYTE;
               endcase
            end
            BUR_BANK3: begin
               case (st_ff.idx[2:0])
                  OFF_DATA: rd_byte = MODULE_REV;
                  OFF_ENAB: rd_byte = {st_ff.sel[SEL_EN_BIT],
                                       st_ff.ctrl.line_format};
                  OFF_EVID: rd_byte = st_ff.ctrl.fifo_setup;
                  default: rd_byte = RST_BYTE;
               endcase
            end
            default: rd_byte = RST_BYTE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // next state: bus slave, register writes, events
   // ------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.ctrl.tx_load = 1'b0;
      nxt_st.ctrl.rx_pop = 1'b0;
      // fifo reset bits only live for one cycle
      nxt_st.ctrl.fifo_setup = st_ff.ctrl.fifo_setup & FS_KEEP_MASK;
      nxt_st.hresp = 1'b0;
      case (st_ff.phase)
         // address phase: capture, hold ready low for one cycle
         BUR_IDLE: begin
            if (hsel && htrans[1] && hready) begin
               nxt_st.phase = BUR_ACCESS;
               nxt_st.idx = haddr[5:2];
               nxt_st.hit = (haddr[1:0] == 2'h0) && (haddr[31:6] == 26'h0)
                            && (haddr[5:2] <= IDX_LAST) && (hsize == 3'h2);
               nxt_st.wr = hwrite;
               nxt_st.hready = 1'b0;
            end
         end
         // data phase: hwdata is stable, act and answer
         BUR_ACCESS: begin
            nxt_st.phase = BUR_IDLE;
            nxt_st.hready = 1'b1;
            nxt_st.hrdata = 32'h0;
            if (st_ff.hit && !st_ff.wr) begin
               if (st_ff.idx == IDX_IRQ_STAT) begin
                  nxt_st.hrdata = {25'h0, st_ff.status};
               end else if (st_ff.idx == IDX_IRQ_MASK) begin
                  nxt_st.hrdata = {25'h0, st_ff.mask};
               end else begin
                  nxt_st.hrdata = {24'h0, rd_byte};
                  // reading the data port pops the receiver
                  nxt_st.ctrl.rx_pop = (bank == BUR_BANK0)
                                       && (st_ff.idx[2:0] == OFF_DATA);
               end
            end
            // unmapped, reserved and read-only writes fall through
            if (st_ff.hit && st_ff.wr) begin
               if (st_ff.idx == IDX_IRQ_MASK) begin
                  nxt_st.mask = hwdata[EV_W-1:0];
               end else if (st_ff.idx == IDX_IRQ_STAT) begin
                  // write one clears; a new event below still wins
                  nxt_st.status = st_ff.status & ~hwdata[EV_W-1:0];
               end else if (st_ff.idx[2:0] == OFF_LFBS) begin
                  // bit 7 turns the write into a selector
                  nxt_st.sel = wbyte;
                  if (!wbyte[SEL_EN_BIT]) begin
                     nxt_st.ctrl.line_format = wbyte[6:0];
                  end
               end else begin
                  case (bank)
                     BUR_BANK0: begin
                        case (st_ff.idx[2:0])
                           OFF_DATA: begin
                              nxt_st.ctrl.tx_byte = wbyte;
                              nxt_st.ctrl.tx_load = 1'b1;
                           end
                           OFF_ENAB: nxt_st.enables = wbyte & en_mask;
                           OFF_EVID: nxt_st.ctrl.fifo_setup = wbyte;
                           OFF_MCTL: nxt_st.ctrl.modem_ctl = wbyte &
                              (ext_mode ? MC_EXT_MASK : MC_STD_MASK);
                           OFF_AUXS: begin
                              if (!ext_mode) begin
                                 nxt_st.scratch = wbyte;
                              end
                           end
                           default: nxt_st.scratch = st_ff.scratch;
                        endcase
                     end
                     BUR_BANK1: begin
                        if (st_ff.idx[2:0] == OFF_DATA) begin
                           nxt_st.ctrl.legacy_div[7:0] = wbyte;
                        end else if (st_ff.idx[2:0] == OFF_ENAB) begin
                           nxt_st.ctrl.legacy_div[15:8] = wbyte;
                        end
                     end
                     BUR_BANK2: begin
                        case (st_ff.idx[2:0])
                           OFF_DATA: nxt_st.ctrl.divisor[7:0] = wbyte;
                           OFF_ENAB: nxt_st.ctrl.divisor[15:8] = wbyte;
                           OFF_EVID: nxt_st.ctrl.ext_one = wbyte;
                           OFF_MCTL: nxt_st.ctrl.ext_two = wbyte;
                           default: nxt_st.ctrl.ext_two = st_ff.ctrl.ext_two;
                        endcase
                     end
                     default: nxt_st.sel = st_ff.sel;
                  endcase
               end
            end
         end
         default: nxt_st.phase = BUR_IDLE;
      endcase
      // events set sticky bits; set beats a same-cycle clear
      nxt_st.status = nxt_st.status | link_in.events;
      nxt_st.irq = |(nxt_st.status & nxt_st.mask);
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_ff <= '0;
         st_ff.phase <= BUR_IDLE;
         st_ff.hready <= 1'b1;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   assign hreadyout = st_ff.hready;
   assign hresp = st_ff.hresp;
   assign hrdata = st_ff.hrdata;
   assign ctrl = st_ff.ctrl;
   assign irq = st_ff.irq;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset || !clk_en);

   property p_bank2_decode;
      st_ff.sel == SEL_BANK2 |-> bank == BUR_BANK2;
   endproperty
   a_bank2_decode: assert property (p_bank2_decode)
      else $error("bank 2 selector not decoded");

   property p_selector_write;
      st_ff.phase == BUR_ACCESS && st_ff.hit && st_ff.wr &&
      st_ff.idx == {1'b0, OFF_LFBS}
      |=> st_ff.sel == $past(hwdata[7:0]);
   endproperty
   a_selector_write: assert property (p_selector_write)
      else $error("offset 3 write did not reach selector");

   property p_sel_keeps_format;
      st_ff.phase == BUR_ACCESS && st_ff.hit && st_ff.wr && hwdata[SEL_EN_BIT]
      && st_ff.idx == {1'b0, OFF_LFBS} |=> $stable(st_ff.ctrl.line_format);
   endproperty
   a_sel_keeps_format: assert property (p_sel_keeps_format)
      else $error("selector write changed line format");

   property p_one_wait;
      st_ff.phase == BUR_IDLE && hsel && htrans[1] && hready
      |=> !hreadyout ##1 hreadyout;
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("bus answer not after one wait cycle");

   property p_tx_load;
      ctrl.tx_load |-> bank == BUR_BANK0 && $past(st_ff.wr)
                       && $past(st_ff.idx) == {1'b0, OFF_DATA};
   endproperty
   a_tx_load: assert property (p_tx_load)
      else $error("tx load without bank 0 data write");

   property p_idle_id;
      !ext_mode && (link_in.events & ev_en) == EV_ZERO |-> evid[0];
   endproperty
   a_idle_id: assert property (p_idle_id)
      else $error("no-pending flag low without event");

   property p_ext_mcr;
      ext_mode && st_ff.phase == BUR_ACCESS && st_ff.hit && st_ff.wr &&
      bank == BUR_BANK0 && st_ff.idx == {1'b0, OFF_MCTL}
      |=> (st_ff.ctrl.modem_ctl & ~MC_EXT_MASK) == RST_BYTE;
   endproperty
   a_ext_mcr: assert property (p_ext_mcr)
      else $error("extended modem control took reserved bits");

   property p_id_read;
      st_ff.phase == BUR_ACCESS && st_ff.hit && !st_ff.wr &&
      bank == BUR_BANK3 && st_ff.idx == {1'b0, OFF_DATA}
      |=> hrdata == {24'h0, MODULE_REV};
   endproperty
   a_id_read: assert property (p_id_read)
      else $error("id read returned wrong value");

   property p_reserved_read;
      st_ff.phase == BUR_ACCESS && !st_ff.wr &&
      (!st_ff.hit || bank == BUR_BANK_NONE && st_ff.idx < IDX_IRQ_STAT
       && st_ff.idx[2:0] != OFF_LFBS)
      |=> hrdata == 32'h0;
   endproperty
   a_reserved_read: assert property (p_reserved_read)
      else $error("reserved read not zero");

   property p_irq_level;
      clk_en |=> irq == |($past(nxt_st.status) & $past(nxt_st.mask));
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt out of step with status");

   c_bank3: cover property (bank == BUR_BANK3 && st_ff.phase == BUR_ACCESS);
   c_rx_pop: cover property (ctrl.rx_pop);
   c_irq: cover property (irq ##1 !irq);

endmodule : bur_regs

// ===== bur_link_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// far-side serial engine model
// ----------------------------------------
module bur_link_model
   import bur_pkg::*;
(
   input wire logic sys_clk,        // clock
   input wire logic reset,          // sync reset
   input wire bur_ctrl_s ctrl,      // controls from the block
   input wire logic [EV_W-1:0] ev,  // event levels from the bench
   output bur_link_in_s link_in     // engine state to the block
);
   logic [7:0] rx_ff; // head of receive fifo
   // each pop moves the head on, so stale reads show up
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rx_ff <= 8'h40;
      end else if (ctrl.rx_pop) begin
         rx_ff <= rx_ff + 8'h01;
      end
   end
   // fixed fill levels, live events
   always_comb begin
      link_in = '0;
      link_in.rx_byte = rx_ff;
      link_in.tx_level = 5'h03;
      link_in.rx_level = 5'h07;
      link_in.events = ev;
   end
endmodule : bur_link_model

// ===== banked_uart_register_interface_test.sv
`timescale 1ns/1ps
// ----------------------------------------
// bench for the banked register window
// ----------------------------------------
module banked_uart_register_interface_test;
   import bur_pkg::*;
   logic sys_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic clk_en = 1'b1; // freezes the block while low
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd_v;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, irq;
   logic [EV_W-1:0] ev = EV_ZERO; // event levels
   bur_link_in_s link_in;
   bur_ctrl_s ctrl;
   int mismatches = 0, check_count = 0;
   bur_regs #(.SECOND_PORT(1'b1), .MODULE_REV(8'h3C)) dut (
      .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .link_in(link_in), .ctrl(ctrl),
      .irq(irq));
   bur_link_model far (.sys_clk(sys_clk), .reset(reset), .ctrl(ctrl),
      .ev(ev), .link_in(link_in));
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic end_sim;
      $display("mismatches=%0d checks=%0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // bounded wait for an edge that sees hready high
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 20) begin
            mismatches++;
            end_sim();
         end
         @(posedge sys_clk);
      end
   endtask : wait_rdy
   // one single-word transfer; read data lands in rd_v
   task automatic xfer(input logic w, input logic [3:0] i,
         input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {26'h0, i, 2'h0};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd_v = hrdata;
   endtask : xfer
   task automatic t_bank0;
      xfer(1'b1, 4'h0, 32'hA5);
      chk(32'(ctrl.tx_byte), 32'hA5);
      xfer(1'b0, 4'h0, 32'h0);
      chk(rd_v, 32'h40);
      xfer(1'b0, 4'h0, 32'h0);
      chk(rd_v, 32'h41);
      xfer(1'b1, 4'h3, 32'h1B);
      chk(32'(ctrl.line_format), 32'h1B);
   endtask : t_bank0
   task automatic t_irq;
      xfer(1'b1, 4'h1, 32'h04);
      xfer(1'b1, 4'h9, 32'h04);
      ev <= 7'h04;
      xfer(1'b0, 4'h2, 32'h0);
      chk(rd_v, 32'h06);
      chk(32'(irq), 32'h1);
      ev <= EV_ZERO;
      xfer(1'b1, 4'h8, 32'h04);
      xfer(1'b0, 4'h2, 32'h0);
      chk(rd_v, 32'h01);
      chk(32'(irq), 32'h0);
      xfer(1'b0, 4'hA, 32'h0);
      chk(rd_v, 32'h0);
      chk(32'(hresp), 32'h0);
      xfer(1'b1, 4'h7, 32'h5A);
      xfer(1'b0, 4'h7, 32'h0);
      chk(rd_v, 32'h5A);
      clk_en <= 1'b0;
      ev <= 7'h04;
      repeat (3) @(posedge sys_clk);
      chk(32'(irq), 32'h0);
      clk_en <= 1'b1;
      ev <= EV_ZERO;
   endtask : t_irq
   task automatic t_banks;
      xfer(1'b1, 4'h3, 32'hE0);
      xfer(1'b1, 4'h0, 32'h34);
      xfer(1'b1, 4'h1, 32'h12);
      chk(32'(ctrl.divisor), 32'h1234);
      xfer(1'b0, 4'h3, 32'h0);
      chk(rd_v, 32'hE0);
      xfer(1'b0, 4'h6, 32'h0);
      chk(rd_v, 32'h03);
      xfer(1'b1, 4'h3, 32'h80);
      xfer(1'b1, 4'h1, 32'h56);
      xfer(1'b0, 4'h1, 32'h0);
      chk(rd_v, 32'h56);
      xfer(1'b0, 4'h2, 32'h0);
      chk(rd_v, 32'h0);
      xfer(1'b1, 4'h3, 32'hE4);
      xfer(1'b1, 4'h0, 32'hFF);
      xfer(1'b0, 4'h0, 32'h0);
      chk(rd_v, 32'h3C);
      xfer(1'b0, 4'h1, 32'h0);
      chk(rd_v, 32'h9B);
      xfer(1'b1, 4'h3, 32'hC1);
      xfer(1'b0, 4'h1, 32'h0);
      chk(rd_v, 32'h56);
   endtask : t_banks
   task automatic t_ext;
      xfer(1'b1, 4'h3, 32'hE0);
      xfer(1'b1, 4'h2, 32'h01);
      xfer(1'b1, 4'h3, 32'h1B);
      xfer(1'b1, 4'h1, 32'hFF);
      xfer(1'b0, 4'h1, 32'h0);
      chk(rd_v, 32'h3F);
      xfer(1'b1, 4'h4, 32'hFF);
      chk(32'(ctrl.modem_ctl), 32'h0B);
      ev <= 7'h40;
      xfer(1'b0, 4'h7, 32'h0);
      chk(rd_v, 32'h01);
   endtask : t_ext
   initial begin
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      chk(32'(hreadyout), 32'h1);
      chk(32'(ctrl.divisor), 32'h0);
      t_bank0();
      t_irq();
      t_banks();
      t_ext();
      end_sim();
   end
endmodule : banked_uart_register_interface_test
